// ---- verilog/uig_top.sv ----
`timescale 1ns/10ps
`include "uig_regs.svh"

module uig_top
(
	// Clock and reset.
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_resetn,

	// Subaddress and subdata register pair.
	input  wire logic                   i_subaddr_wr,
	input  wire uig_pkg::uig_byte_t     i_subaddr_wdata,
	input  wire logic                   i_subdata_wr,
	input  wire logic                   i_subdata_rd,
	input  wire uig_pkg::uig_byte_t     i_subdata_wdata,
	output logic [7:0]                  o_subdata_rdata,
	output logic [7:0]                  o_subaddress_index,

	// Protocol request levels from the protocol flag register.
	input  wire logic                   i_setup_data_valid_flag,
	input  wire logic                   i_frame_start_flag,
	input  wire logic                   i_setup_token_flag,
	input  wire logic                   i_bus_suspend_flag,
	input  wire logic                   i_bus_reset_flag,

	// Endpoint completion events, one-cycle pulses.
	input  wire uig_pkg::uig_ep_flags_t i_in_ep_acked,
	input  wire uig_pkg::uig_ep_flags_t i_out_ep_good_rx,

	// Status toward the module.
	output logic                        o_usb_clock_stop,
	output logic                        o_irq_pending,
	output logic [4:0]                  o_irq_source_code,
	output logic [3:0]                  o_in_ep_done_flag,
	output logic [3:0]                  o_out_ep_done_flag
);

	// Carriers for the two completion flag banks.
	uig_flag_if in_flags();
	uig_flag_if out_flags();

	// Registers.
	uig_pkg::uig_byte_t   subaddress_index_reg;
	logic                 clock_stop_reg;
	logic                 clock_stop_next;
	uig_pkg::uig_byte_t   irq_source_id_reg;
	uig_pkg::uig_byte_t   irq_source_id_next;
	uig_pkg::uig_byte_t   rdata_reg;
	uig_pkg::uig_byte_t   rdata_next;
	logic                 irq_pending_reg;

	// Decode of the selected subregister.
	wire logic sel_clock_stop;
	wire logic sel_irq_id;
	wire logic sel_in_flags;
	wire logic sel_out_flags;
	wire logic wr_clock_stop;
	wire logic wr_in_flags;
	wire logic wr_out_flags;

	assign sel_clock_stop = (subaddress_index_reg == `UIG_SA_CLOCK_STOP);
	assign sel_irq_id     = (subaddress_index_reg == `UIG_SA_IRQ_ID);
	assign sel_in_flags   = (subaddress_index_reg == `UIG_SA_IN_FLAGS);
	assign sel_out_flags  = (subaddress_index_reg == `UIG_SA_OUT_FLAGS);

	assign wr_clock_stop  = i_subdata_wr & sel_clock_stop;
	assign wr_in_flags    = i_subdata_wr & sel_in_flags;
	assign wr_out_flags   = i_subdata_wr & sel_out_flags;

	// Clock stop.
	// The stored byte is irrelevant; only the fact of a write matters.
	// The stop is released only by reset, since the module cannot wake itself.
	assign clock_stop_next = clock_stop_reg | wr_clock_stop;

	// Endpoint events.
	// With the module clock stopped no packet can complete, so events are held off.
	wire logic ev_enable;

	assign ev_enable = ~clock_stop_reg;

	assign in_flags.set  = i_in_ep_acked & {4{ev_enable}};
	assign out_flags.set = i_out_ep_good_rx & {4{ev_enable}};

	// Only ones clear; zeros leave the flag alone.
	assign in_flags.clr  = wr_in_flags ?
		i_subdata_wdata[`UIG_EP_FLAG_MSB:`UIG_EP_FLAG_LSB] : 4'h0;
	assign out_flags.clr = wr_out_flags ?
		i_subdata_wdata[`UIG_EP_FLAG_MSB:`UIG_EP_FLAG_LSB] : 4'h0;

	uig_flag_bank u_in_bank
	(
		.i_ref_clk (i_ref_clk),
		.i_resetn  (i_resetn),
		.flag_port (in_flags)
	);

	uig_flag_bank u_out_bank
	(
		.i_ref_clk (i_ref_clk),
		.i_resetn  (i_resetn),
		.flag_port (out_flags)
	);

	// Request vector indexed by source code.
	// Index five is the unused code and never requests.
	wire logic [13:0] req_vec;

	assign req_vec = {
		out_flags.flags[3], in_flags.flags[3],
		out_flags.flags[2], in_flags.flags[2],
		out_flags.flags[1], in_flags.flags[1],
		out_flags.flags[0], in_flags.flags[0],
		1'b0,
		i_bus_reset_flag,
		i_bus_suspend_flag,
		i_setup_token_flag,
		i_frame_start_flag,
		i_setup_data_valid_flag
	};

	// Priority encoder.
	// Scanning from the top down lets the lowest pending code win.
	uig_pkg::uig_code_t code_now;
	logic               any_req;

	always_comb
	begin
		code_now = `UIG_CODE_SETUP_DATA;
		any_req  = 1'b0;
		for (int i = 13; i >= 0; i--)
		begin
			if (req_vec[i])
			begin
				code_now = 5'(i);
				any_req  = 1'b1;
			end
		end
	end

	// Bits 7 and 1:0 stay zero. With nothing pending the code falls back to zero.
	assign irq_source_id_next = {1'b0, code_now, 2'b00};

	// Read data.
	// The source code is read straight from the encoder so that a read just
	// after a clear already shows the next pending source.
	wire uig_pkg::uig_byte_t in_flags_rd;
	wire uig_pkg::uig_byte_t out_flags_rd;

	assign in_flags_rd  = {4'h0, in_flags.flags};
	assign out_flags_rd = {4'h0, out_flags.flags};

	always_comb
	begin
		rdata_next = rdata_reg;
		if (i_subdata_rd)
		begin
			case (1'b1)
				sel_clock_stop: rdata_next = 8'h00;
				sel_irq_id:     rdata_next = irq_source_id_next;
				sel_in_flags:   rdata_next = in_flags_rd;
				sel_out_flags:  rdata_next = out_flags_rd;
				default:        rdata_next = 8'h00;
			endcase
		end
	end

	// Subaddress index.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
			subaddress_index_reg <= `UIG_RST_SUBADDR;
		else if (i_subaddr_wr)
			subaddress_index_reg <= i_subaddr_wdata;
	end

	// Clock stop state.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
			clock_stop_reg <= `UIG_RST_CLOCK_STOP;
		else
			clock_stop_reg <= clock_stop_next;
	end

	// Source identification, refreshed every cycle; writes to it are ignored.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
		begin
			irq_source_id_reg <= `UIG_RST_IRQ_ID;
			irq_pending_reg   <= `UIG_RST_PENDING;
		end
		else
		begin
			irq_source_id_reg <= irq_source_id_next;
			irq_pending_reg   <= any_req;
		end
	end

	// Read data register.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
			rdata_reg <= `UIG_RST_RDATA;
		else
			rdata_reg <= rdata_next;
	end

	// Outputs, all from flip-flops.
	assign o_subdata_rdata    = rdata_reg;
	assign o_subaddress_index = subaddress_index_reg;
	assign o_usb_clock_stop   = clock_stop_reg;
	assign o_irq_pending      = irq_pending_reg;
	assign o_irq_source_code  = irq_source_id_reg[`UIG_ID_CODE_MSB:`UIG_ID_CODE_LSB];
	assign o_in_ep_done_flag  = in_flags.flags;
	assign o_out_ep_done_flag = out_flags.flags;

endmodule

// ---- verilog/uig_regs.svh ----
`ifndef UIG_REGS_SVH
`define UIG_REGS_SVH

// Subaddress indexes reached through the subdata register.
`define UIG_SA_CLOCK_STOP     8'h10
`define UIG_SA_IRQ_ID         8'h28
`define UIG_SA_IN_FLAGS       8'h29
`define UIG_SA_OUT_FLAGS      8'h2A

// Reset values.
`define UIG_RST_SUBADDR       8'h00
`define UIG_RST_CLOCK_STOP    1'h0
`define UIG_RST_IRQ_ID        8'h00
`define UIG_RST_EP_FLAGS      4'h0
`define UIG_RST_RDATA         8'h00
`define UIG_RST_PENDING       1'h0

// Field positions.
`define UIG_ID_CODE_MSB       6
`define UIG_ID_CODE_LSB       2
`define UIG_EP_FLAG_MSB       3
`define UIG_EP_FLAG_LSB       0

// Source codes of the protocol requests.
`define UIG_CODE_SETUP_DATA   5'h00
`define UIG_CODE_FRAME_START  5'h01
`define UIG_CODE_SETUP_TOKEN  5'h02
`define UIG_CODE_SUSPEND      5'h03
`define UIG_CODE_BUS_RESET    5'h04
`define UIG_CODE_RESERVED     5'h05
// Endpoint codes: IN of endpoint x at base + 2x, OUT one above it.
`define UIG_CODE_EP_BASE      5'h06
`define UIG_CODE_LAST         5'h0D

`endif

// ---- verilog/uig_pkg.sv ----
package uig_pkg;

	typedef logic [7:0] uig_byte_t;
	typedef logic [4:0] uig_code_t;
	typedef logic [3:0] uig_ep_flags_t;

endpackage

// ---- verilog/uig_flag_if.sv ----
`timescale 1ns/10ps

interface uig_flag_if;
	uig_pkg::uig_ep_flags_t set;
	uig_pkg::uig_ep_flags_t clr;
	uig_pkg::uig_ep_flags_t flags;

	modport bank
	(
		input  set,
		input  clr,
		output flags
	);

	modport ctrl
	(
		output set,
		output clr,
		input  flags
	);
endinterface

// ---- verilog/uig_flag_bank.sv ----
`timescale 1ns/10ps
`include "uig_regs.svh"

module uig_flag_bank
(
	// Clock and reset.
	input  wire logic  i_ref_clk,
	input  wire logic  i_resetn,
	// Flag port.
	uig_flag_if.bank   flag_port
);

	uig_pkg::uig_ep_flags_t flags_reg;
	uig_pkg::uig_ep_flags_t flags_next;

	// A set arriving in the cycle of its clear wins, so no event is lost.
	assign flags_next = (flags_reg & ~flag_port.clr) | flag_port.set;

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
			flags_reg <= `UIG_RST_EP_FLAGS;
		else
			flags_reg <= flags_next;
	end

	assign flag_port.flags = flags_reg;

endmodule

// ---- dv/uig_host_model.sv ----
`timescale 1ns/10ps

module uig_host_model
(
	// Clock.
	input  wire logic        i_ref_clk,
	// Bench command: out pulses, in pulses, protocol levels.
	input  wire logic [12:0] i_evt,
	// Bus events as the device sees them.
	output logic      [4:0]  o_proto = 5'h00,
	output logic      [3:0]  o_in_ack = 4'h0,
	output logic      [3:0]  o_out_rx = 4'h0
);
	// A plain always is used because the outputs carry a start value that keeps the
	// device inputs known while reset is still held.
	always @(posedge i_ref_clk)
	begin
		o_proto <= i_evt[4:0];
		o_in_ack <= i_evt[8:5];
		o_out_rx <= i_evt[12:9];
	end
endmodule

// ---- dv/uig_checker.sv ----
`timescale 1ns/10ps

module uig_checker
(
	// Clock, reset and register pair.
	input wire logic       i_ref_clk,
	input wire logic       i_resetn,
	input wire logic       i_subdata_wr,
	input wire logic       i_subdata_rd,
	input wire logic [7:0] i_subdata_wdata,
	input wire logic [7:0] o_subdata_rdata,
	input wire logic [7:0] o_subaddress_index,
	// Requests and status.
	input wire logic       i_setup_data_valid_flag,
	input wire logic       i_frame_start_flag,
	input wire logic [3:0] i_in_ep_acked,
	input wire logic [3:0] i_out_ep_good_rx,
	input wire logic       o_usb_clock_stop,
	input wire logic       o_irq_pending,
	input wire logic [4:0] o_irq_source_code,
	input wire logic [3:0] o_in_ep_done_flag
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	wire at_stop = o_subaddress_index == 8'h10;
	wire at_id = o_subaddress_index == 8'h28;
	wire at_in = o_subaddress_index == 8'h29;
	wire run = !o_usb_clock_stop;
	property p_stop; i_subdata_wr && at_stop |=> o_usb_clock_stop; endproperty
	a_stop: assert property (p_stop) else $error("clock stop not set");
	property p_stop_rd; i_subdata_rd && at_stop |=> o_subdata_rdata == 8'h00; endproperty
	a_stop_rd: assert property (p_stop_rd) else $error("clock stop read");
	property p_id_rsv; i_subdata_rd && at_id |=> o_subdata_rdata[7] == 1'b0
		&& o_subdata_rdata[1:0] == 2'h0; endproperty
	a_id_rsv: assert property (p_id_rsv) else $error("id reserved bits");
	property p_top; i_setup_data_valid_flag |=> o_irq_pending && o_irq_source_code == 5'h00;
	endproperty
	a_top: assert property (p_top) else $error("top source");
	property p_sof; !i_setup_data_valid_flag && i_frame_start_flag |=> o_irq_source_code == 5'h01;
	endproperty
	a_sof: assert property (p_sof) else $error("frame start code");
	property p_in_set; i_in_ep_acked[0] && run |=> o_in_ep_done_flag[0]; endproperty
	a_in_set: assert property (p_in_set) else $error("in flag not set");
	property p_out_set; i_out_ep_good_rx[3] && run |=> ##1 o_irq_pending; endproperty
	a_out_set: assert property (p_out_set) else $error("out pending");
	property p_in_clr; i_subdata_wr && at_in && i_subdata_wdata[1] && !i_in_ep_acked[1]
		|=> !o_in_ep_done_flag[1]; endproperty
	a_in_clr: assert property (p_in_clr) else $error("in flag not cleared");
	c_stop: cover property (o_usb_clock_stop);
	c_last: cover property (o_irq_source_code == 5'h0D);
	c_pend: cover property (o_irq_pending && o_in_ep_done_flag[3]);
endmodule

bind uig_top uig_checker u_chk
(
	.i_ref_clk               (i_ref_clk),
	.i_resetn                (i_resetn),
	.i_subdata_wr            (i_subdata_wr),
	.i_subdata_rd            (i_subdata_rd),
	.i_subdata_wdata         (i_subdata_wdata),
	.o_subdata_rdata         (o_subdata_rdata),
	.o_subaddress_index      (o_subaddress_index),
	.i_setup_data_valid_flag (i_setup_data_valid_flag),
	.i_frame_start_flag      (i_frame_start_flag),
	.i_in_ep_acked           (i_in_ep_acked),
	.i_out_ep_good_rx        (i_out_ep_good_rx),
	.o_usb_clock_stop        (o_usb_clock_stop),
	.o_irq_pending           (o_irq_pending),
	.o_irq_source_code       (o_irq_source_code),
	.o_in_ep_done_flag       (o_in_ep_done_flag)
);

// ---- dv/usb_irq_id_and_clock_gate_tb.sv ----
`timescale 1ns/10ps

module usb_irq_id_and_clock_gate_tb;
	logic        clk = 1'b0, rstn = 1'b0, sa_wr = 1'b0, sd_wr = 1'b0, sd_rd = 1'b0;
	logic [7:0]  sa_d = 8'h00, wd = 8'h00, rd, idx, q;
	logic [12:0] evt = 13'h0000;
	logic [4:0]  proto, code;
	logic [3:0]  in_ack, out_rx, in_f, out_f;
	logic        stop, pend;
	int          errors = 0, total_checks = 0;
	// Each row: {out pulses, in pulses, protocol levels, expected code}.
	logic [17:0] rows [13] = '{{13'h001F, 5'h00}, {13'h001E, 5'h01}, {13'h001C, 5'h02},
		{13'h0018, 5'h03}, {13'h0030, 5'h04}, {13'h1FE0, 5'h06}, {13'h1FC0, 5'h07},
		{13'h1DC0, 5'h08}, {13'h1D80, 5'h09}, {13'h1980, 5'h0A}, {13'h1900, 5'h0B},
		{13'h1100, 5'h0C}, {13'h1000, 5'h0D}};

	uig_host_model HOST (.i_ref_clk(clk), .i_evt(evt), .o_proto(proto), .o_in_ack(in_ack),
		.o_out_rx(out_rx));
	uig_top DUT (.i_ref_clk(clk), .i_resetn(rstn), .i_subaddr_wr(sa_wr), .i_subaddr_wdata(sa_d),
		.i_subdata_wr(sd_wr), .i_subdata_rd(sd_rd), .i_subdata_wdata(wd), .o_subdata_rdata(rd),
		.o_subaddress_index(idx), .i_setup_data_valid_flag(proto[0]),
		.i_frame_start_flag(proto[1]), .i_setup_token_flag(proto[2]),
		.i_bus_suspend_flag(proto[3]), .i_bus_reset_flag(proto[4]), .i_in_ep_acked(in_ack),
		.i_out_ep_good_rx(out_rx), .o_usb_clock_stop(stop), .o_irq_pending(pend),
		.o_irq_source_code(code), .o_in_ep_done_flag(in_f), .o_out_ep_done_flag(out_f));

	always #50 clk = ~clk;

	task chk(input logic [7:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			errors++;
			$display("ERROR t=%0t seen %h exp %h", $time, s, e);
		end
	endtask

	// Index write, then one subdata access using the index registered before it.
	task acc(input logic [7:0] a, d, input logic w);
		@(posedge clk);
		sa_wr <= 1'b1;
		sa_d <= a;
		@(posedge clk);
		sa_wr <= 1'b0;
		sd_wr <= w;
		sd_rd <= !w;
		wd <= d;
		@(posedge clk);
		sd_wr <= 1'b0;
		sd_rd <= 1'b0;
		#1 q = rd;
	endtask

	// Endpoint pulses last one cycle; protocol levels stay until the next call.
	task ev(input logic [12:0] e);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= {8'h00, e[4:0]};
		repeat (3) @(posedge clk);
		#1;
	endtask

	task complete_run;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		repeat (1000) @(posedge clk);
		errors++;
		complete_run();
	end

	initial
	begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 13; i++)
		begin
			ev(rows[i][17:5]);
			chk({pend, 2'h0, code}, {1'b1, 2'h0, rows[i][4:0]});
			acc(8'h28, 8'hFF, 1'b0);
			chk(q, {1'b0, rows[i][4:0], 2'h0});
			ev(13'h0000);
			acc(8'h29, 8'hFF, 1'b1);
			acc(8'h2A, 8'hFF, 1'b1);
			chk({in_f, out_f}, 8'h00);
		end
		$display("priority table done");
		ev(13'h1040);
		acc(8'h29, 8'hFD, 1'b1);
		chk({4'h0, in_f}, 8'h02);
		acc(8'h29, 8'h02, 1'b1);
		acc(8'h28, 8'h00, 1'b0);
		chk(q, 8'h34);
		acc(8'h2A, 8'h00, 1'b0);
		chk(q, 8'h08);
		acc(8'h28, 8'hFF, 1'b1);
		acc(8'h28, 8'h00, 1'b0);
		chk(q, 8'h34);
		acc(8'h55, 8'h00, 1'b0);
		chk(q, 8'h00);
		$display("clear and reserved done");
		acc(8'h10, 8'h00, 1'b1);
		chk({7'h00, stop}, 8'h01);
		acc(8'h10, 8'h00, 1'b0);
		chk(q, 8'h00);
		ev(13'h0020);
		chk({4'h0, in_f}, 8'h00);
		@(posedge clk);
		rstn <= 1'b0;
		@(posedge clk);
		rstn <= 1'b1;
		#1;
		chk({stop, pend, 1'b0, code}, 8'h00);
		chk({in_f, out_f}, 8'h00);
		chk(idx, 8'h00);
		$display("clock stop and reset done");
		complete_run();
	end
endmodule
